// File: rtl/flash_read_core.sv
// Device-side multi-lane read path of a serial flash
//
// Behaviour
// RQ1 - Dual output read: fast read with data on two lanes.
// RQ2 - Dual output read: eight dummy clocks, input ignored.
// RQ3 - Host releases IO0 before first dual output data.
// RQ4 - Dual I/O read: address and data two bits per clock.
// RQ5 - Dual I/O: address on rise, data on fall, address steps.
// RQ6 - Quad output read: four lanes, needs quad enable.
// RQ7 - Quad output read: eight dummy clocks, input ignored.
// RQ8 - Host releases four lanes before quad output data.
// RQ9 - Quad I/O read: address and data four bits per clock.
// RQ10 - Quad I/O read has six dummy clocks before data.
// RQ11 - Quad I/O read refused unless quad enable is set.
// RQ12 - Quad I/O: address on rise, data on fall, address steps.
// RQ13 - Chip select high ends a read; lanes released.
// RQ14 - Later quad I/O frame may omit the opcode.
// RQ15 - Word read: A0 zero, two dummies, quad enable.
// RQ16 - Wrap on: word reads loop in the page section.
// RQ17 - Octal word read: low four bits zero, no dummies.
// RQ18 - Set wrap: opcode, 24 dummy bits, 8 wrap bits.
// RQ19 - Wrap disable bit: 0 wraps, 1 (default) linear.
// RQ20 - Wrap length bits pick 8, 16, 32 or 64 bytes.
// RQ21 - Wrap settings hold for later quad I/O reads.
// RQ22 - Host leaves wrap by writing disable bit one.
// RQ23 - Array reads refused during a write cycle; opcode-less quad I/O frames skip the write_busy check.
// RQ24 - Fast read: opcode, 3 address bytes, dummy byte.
// RQ25 - Wrap only for quad I/O reads; others linear.
`timescale 1ns/10ps
`default_nettype none
module flash_read_core
    import flash_read_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    input  wire logic                      cs_n,
    input  wire logic                      sclk,
    input  wire logic [3:0]                io_in,
    output var  logic [3:0]                io_out,
    output var  logic [3:0]                io_oe,
    input  wire logic                      quad_enable_bit,
    input  wire logic                      write_busy,
    output var  logic [flash_read_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]                mem_data,
    output var  logic                      cmd_rejected,
    output var  logic                      wrap_disable_bit,
    output var  logic [1:0]                wrap_length_bits,
    output var  logic                      read_active
);
    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic       sclk_d;
    logic       cs_d;
    logic       sclk_s;
    logic       cs_s;
    logic [3:0] io_s;
    logic       rise;
    logic       fall;
    logic       cs_fall;

    pin_sync #(.W(6)) u_sync (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .async_in  ({cs_n, sclk, io_in}),
        .reset_val (6'h20),
        .sync_out  (pins_s)
    );

    assign cs_s = pins_s[5];
    assign sclk_s = pins_s[4];
    assign io_s = pins_s[3:0];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_d   <= cs_s;
        end
    end

    assign rise    = !cs_s && sclk_s && !sclk_d;
    assign fall    = !cs_s && !sclk_s && sclk_d;
    assign cs_fall = cs_d && !cs_s;

    // ------------------------------------------------------------
    // Command state
    // ------------------------------------------------------------
    phase_t            phase;
    lanes_t            addr_lanes;
    lanes_t            data_lanes;
    logic [7:0]        bit_cnt;
    logic [7:0]        dummy_len;
    logic [7:0]        shift_in;
    logic [ADDR_W-1:0] addr_sr;
    logic              wrap_cmd;     // Current read honours wrap
    logic              quad_io_seen; // Opcode may be skipped next frame
    logic              first_byte;

    logic [7:0]        out_sr;
    logic [7:0]        out_left;
    logic [ADDR_W-1:0] next_addr;

    logic [7:0]        in_step;
    logic [7:0]        cmd_byte;

    assign in_step  = lane_bits((phase == ST_CMD || phase == ST_WRAP) ? LANE_1 : addr_lanes);
    assign cmd_byte = {shift_in[6:0], io_s[0]};

    wrap_addr u_wrap (
        .cur_addr  (mem_addr),
        .wrap_on   (wrap_cmd && !wrap_disable_bit),
        .wrap_len  (wrap_length_bits),
        .next_addr (next_addr)
    );

    // Shift in bits on the rising edge, lane count by phase
    function automatic logic [7:0] shift_lanes(input logic [7:0] sr, input logic [3:0] d, input lanes_t l);
        case (l)
            LANE_2:  shift_lanes = {sr[5:0], d[1:0]};
            LANE_4:  shift_lanes = {sr[3:0], d};
            default: shift_lanes = {sr[6:0], d[0]};
        endcase
    endfunction

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase        <= ST_IDLE;
            addr_lanes   <= LANE_1;
            data_lanes   <= LANE_1;
            bit_cnt      <= 8'h00;
            dummy_len    <= 8'h00;
            shift_in     <= 8'h00;
            addr_sr      <= '0;
            wrap_cmd     <= 1'b0;
            cmd_rejected <= 1'b0;

        end else if (cs_s) begin
            phase    <= ST_IDLE;                         // see RQ13
            bit_cnt  <= 8'h00;

        end else if (cs_fall || phase == ST_IDLE) begin
            bit_cnt      <= 8'h00;
            cmd_rejected <= 1'b0;
            if (quad_io_seen && quad_enable_bit) begin
                // Opcode-less random access continues the quad I/O read
                phase      <= ST_ADDR;                   // see RQ14
                addr_lanes <= LANE_4;
                data_lanes <= LANE_4;
                dummy_len  <= DUMMY_QUAD_IO;
                wrap_cmd   <= 1'b1;
            end else begin
                phase <= ST_CMD;
            end

        end else if (rise) begin
            shift_in <= shift_lanes(shift_in, io_s,
                                    (phase == ST_CMD || phase == ST_WRAP) ? LANE_1 : addr_lanes);
            bit_cnt  <= bit_cnt + in_step;
            case (phase)
                ST_CMD: begin
                    if (bit_cnt + 8'd1 == CMD_BITS) begin
                        bit_cnt  <= 8'h00;
                        wrap_cmd <= 1'b0;                // see RQ25
                        phase    <= ST_ADDR;
                        case (cmd_byte)
                            OP_FAST_READ: begin          // see RQ24
                                addr_lanes <= LANE_1;
                                data_lanes <= LANE_1;
                                dummy_len  <= DUMMY_SINGLE;
                            end

                            OP_DUAL_OUT: begin           // see RQ1
                                addr_lanes <= LANE_1;
                                data_lanes <= LANE_2;
                                dummy_len  <= DUMMY_DUAL_OUT; // see RQ2
                            end

                            OP_DUAL_IO: begin            // see RQ4
                                addr_lanes <= LANE_2;
                                data_lanes <= LANE_2;
                                dummy_len  <= DUMMY_DUAL_IO;
                            end

                            OP_QUAD_OUT: begin           // see RQ6
                                addr_lanes <= LANE_1;
                                data_lanes <= LANE_4;
                                dummy_len  <= DUMMY_QUAD_OUT; // see RQ7
                            end

                            OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_OCTAL: begin // see RQ9
                                addr_lanes <= LANE_4;
                                data_lanes <= LANE_4;
                                wrap_cmd   <= 1'b1;      // see RQ21
                                if (cmd_byte == OP_QUAD_WORD)
                                    dummy_len <= DUMMY_WORD;   // see RQ15
                                else if (cmd_byte == OP_QUAD_OCTAL)
                                    dummy_len <= DUMMY_OCTAL;  // see RQ17
                                else
                                    dummy_len <= DUMMY_QUAD_IO; // see RQ10
                            end

                            OP_SET_WRAP: begin           // see RQ18
                                addr_lanes <= LANE_1;
                                phase      <= ST_WRAP;
                            end

                            default: phase <= ST_SKIP;
                        endcase

                        // Quad commands need quad enable; array reads refused while write busy
                        if ((!quad_enable_bit && (cmd_byte == OP_QUAD_OUT || cmd_byte == OP_QUAD_IO
                             || cmd_byte == OP_QUAD_WORD || cmd_byte == OP_QUAD_OCTAL))  // see RQ11
                            || (write_busy && cmd_byte != OP_SET_WRAP)) begin           // see RQ23
                            phase        <= ST_SKIP;
                            cmd_rejected <= 1'b1;
                        end
                    end
                end

                ST_ADDR: begin                           // see RQ5
                    addr_sr <= (addr_lanes == LANE_4) ? {addr_sr[ADDR_W-5:0], io_s}
                             : (addr_lanes == LANE_2) ? {addr_sr[ADDR_W-3:0], io_s[1:0]}
                             : {addr_sr[ADDR_W-2:0], io_s[0]};
                    if (bit_cnt + in_step == ADDR_BITS) begin
                        bit_cnt <= 8'h00;
                        phase   <= (dummy_len == 8'h00) ? ST_DATA : ST_DUMMY;
                    end
                end

                ST_DUMMY: begin
                    // Dummy clocks counted per clock, lane input ignored
                    bit_cnt <= bit_cnt + 8'd1;
                    if (bit_cnt + 8'd1 == dummy_len) begin
                        bit_cnt <= 8'h00;
                        phase   <= ST_DATA;
                    end
                end

                ST_WRAP: begin
                    if (bit_cnt + 8'd1 == WRAP_DUMMY_BITS + WRAP_DATA_BITS) begin
                        phase <= ST_SKIP;                // Awaits chip select rise
                    end
                end

                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Wrap settings, held across frames
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrap_disable_bit <= WRAP_RESET[0];           // see RQ19
            wrap_length_bits <= WRAP_RESET[2:1];

        end else if (rise && phase == ST_WRAP
                     && bit_cnt + 8'd1 == WRAP_DUMMY_BITS + WRAP_DATA_BITS) begin
            wrap_disable_bit <= cmd_byte[WRAP_DIS_POS];  // see RQ22
            wrap_length_bits <= cmd_byte[WRAP_LEN_LO +: 2]; // see RQ20
        end
    end

    // ------------------------------------------------------------
    // Remember quad I/O for opcode-less follow-up frames
    // ------------------------------------------------------------
    // Limitation: no mode byte exists, so any quad I/O read arms it at its first data falling edge
    always_ff @(posedge clk_sys) begin
        if (srst)
            quad_io_seen <= 1'b0;
        else if (phase == ST_DATA && wrap_cmd && !first_byte)
            quad_io_seen <= 1'b1;                        // see RQ14

        else if (phase == ST_CMD && rise)
            quad_io_seen <= 1'b0;
    end

    // ------------------------------------------------------------
    // Data output on falling edges
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mem_addr    <= '0;
            first_byte  <= 1'b1;
            out_sr      <= 8'h00;
            out_left    <= 8'h00;
            io_out      <= 4'h0;
            io_oe       <= 4'h0;
            read_active <= 1'b0;

        end else if (phase != ST_DATA) begin
            io_oe       <= 4'h0;                         // see RQ13
            read_active <= 1'b0;
            first_byte  <= 1'b1;
            out_left    <= 8'h00;
            if (phase == ST_ADDR || phase == ST_DUMMY)
                mem_addr <= addr_sr;
        end else begin
            read_active <= 1'b1;

            if (first_byte && !fall)
                mem_addr <= addr_sr;

            if (fall) begin
                // Byte start loads this address, then steps it
                if (out_left == 8'h00) begin
                    mem_addr   <= next_addr;             // see RQ16
                    first_byte <= 1'b0;
                end

                case (data_lanes)
                    LANE_4: begin                        // see RQ12
                        io_oe  <= 4'hf;
                        io_out <= (out_left == 8'h00) ? mem_data[7:4] : out_sr[7:4];
                        out_sr <= (out_left == 8'h00) ? {mem_data[3:0], 4'h0} : {out_sr[3:0], 4'h0};
                        out_left <= (out_left == 8'h00) ? 8'd4 : out_left - 8'd4;
                    end

                    LANE_2: begin                        // see RQ1
                        io_oe  <= 4'h3;
                        io_out <= {2'b00, (out_left == 8'h00) ? mem_data[7:6] : out_sr[7:6]};
                        out_sr <= (out_left == 8'h00) ? {mem_data[5:0], 2'b00} : {out_sr[5:0], 2'b00};
                        out_left <= (out_left == 8'h00) ? 8'd6 : out_left - 8'd2;
                    end

                    default: begin
                        io_oe  <= 4'h2;
                        io_out <= {2'b00, (out_left == 8'h00) ? mem_data[7] : out_sr[7], 1'b0};
                        out_sr <= (out_left == 8'h00) ? {mem_data[6:0], 1'b0} : {out_sr[6:0], 1'b0};
                        out_left <= (out_left == 8'h00) ? 8'd7 : out_left - 8'd1;
                    end
                endcase
            end
        end
    end
endmodule // flash_read_core
`default_nettype wire

// File: rtl/flash_read_pkg.sv
// Constants of the flash read path
package flash_read_pkg;
    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_FAST_READ   = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT    = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO     = 8'hbb;
    localparam logic [7:0] OP_QUAD_OUT    = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO     = 8'heb;
    localparam logic [7:0] OP_QUAD_WORD   = 8'he7;
    localparam logic [7:0] OP_QUAD_OCTAL  = 8'he3;
    localparam logic [7:0] OP_SET_WRAP    = 8'h77;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [7:0] CMD_BITS       = 8'd8;
    localparam logic [7:0] ADDR_BITS      = 8'd24;
    localparam logic [7:0] WRAP_DUMMY_BITS = 8'd24;
    localparam logic [7:0] WRAP_DATA_BITS  = 8'd8;
    localparam logic [7:0] DUMMY_SINGLE   = 8'd8;
    localparam logic [7:0] DUMMY_DUAL_OUT = 8'd8;
    localparam logic [7:0] DUMMY_DUAL_IO  = 8'd4;
    localparam logic [7:0] DUMMY_QUAD_OUT = 8'd8;
    localparam logic [7:0] DUMMY_QUAD_IO  = 8'd6;
    localparam logic [7:0] DUMMY_WORD     = 8'd2;
    localparam logic [7:0] DUMMY_OCTAL    = 8'd0;

    // Wrap field positions in the wrap byte
    localparam int WRAP_DIS_POS = 4;
    localparam int WRAP_LEN_LO  = 5;
    localparam logic [2:0] WRAP_RESET = 3'h1;   // disable bit 1, length 00

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA  = 3'b100,
        ST_WRAP  = 3'b101,
        ST_SKIP  = 3'b110
    } phase_t;

    typedef enum logic [1:0] {
        LANE_1 = 2'b00,
        LANE_2 = 2'b01,
        LANE_4 = 2'b10
    } lanes_t;

    // Bits carried per clock for a lane mode
    function automatic logic [7:0] lane_bits(input lanes_t l);
        case (l)
            LANE_2:  lane_bits = 8'd2;
            LANE_4:  lane_bits = 8'd4;
            default: lane_bits = 8'd1;
        endcase
    endfunction
endpackage

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] reset_val,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta     <= reset_val;
            sync_out <= reset_val;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pin_sync
`default_nettype wire

// File: rtl/wrap_addr.sv
// Next-address calculation with optional section wrap
`timescale 1ns/10ps
`default_nettype none
module wrap_addr
    import flash_read_pkg::*;
(
    input  wire logic [ADDR_W-1:0] cur_addr,
    input  wire logic              wrap_on,
    input  wire logic [1:0]        wrap_len,
    output var  logic [ADDR_W-1:0] next_addr
);
    logic [ADDR_W-1:0] lin;
    logic [ADDR_W-1:0] mask;

    always_comb begin
        lin = cur_addr + 24'h000001;   // Rolls over to zero at the top
        case (wrap_len)
            2'b00:   mask = 24'h000007;
            2'b01:   mask = 24'h00000f;
            2'b10:   mask = 24'h00001f;
            default: mask = 24'h00003f;
        endcase
        if (wrap_on)
            next_addr = (cur_addr & ~mask) | (lin & mask);
        else
            next_addr = lin;
    end
endmodule // wrap_addr
`default_nettype wire

// File: dv/flash_read_core_assertions.sv
// Assertions for the flash read core
`timescale 1ns/10ps
`default_nettype none
module flash_read_core_assertions
    import flash_read_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic              cs_n,
    input wire logic              sclk,
    input wire logic [3:0]        io_out,
    input wire logic [3:0]        io_oe,
    input wire logic              quad_enable_bit,
    input wire logic              write_busy,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              cmd_rejected,
    input wire logic              wrap_disable_bit,
    input wire logic [1:0]        wrap_length_bits,
    input wire logic              read_active
);
    logic [ADDR_W-1:0] sec_mask;
    assign sec_mask = (24'h8 << wrap_length_bits) - 24'h1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_reset_vals;
        $fell(srst) |-> io_oe == 4'h0 && !read_active && !cmd_rejected && wrap_disable_bit && wrap_length_bits == 2'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
    property p_cs_release;
        cs_n [*5] |-> io_oe == 4'h0;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("lanes driven while deselected");
    property p_active_ends;
        $rose(cs_n) |-> ##[1:5] !read_active;
    endproperty
    a_active_ends: assert property (p_active_ends) else $error("data phase outlives frame");
    property p_rejected_silent;
        cmd_rejected |-> io_oe == 4'h0;
    endproperty
    a_rejected_silent: assert property (p_rejected_silent) else $error("rejected frame drives lanes");
    property p_lane_sets;
        io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'h3 || io_oe == 4'hf;
    endproperty
    a_lane_sets: assert property (p_lane_sets) else $error("illegal lane enable set");
    property p_quad_gate;
        $rose(io_oe[3]) |-> quad_enable_bit;
    endproperty
    a_quad_gate: assert property (p_quad_gate) else $error("quad output without quad enable");
    property p_busy_gate;
        $rose(io_oe[1]) |-> !write_busy;
    endproperty
    a_busy_gate: assert property (p_busy_gate) else $error("array read during write cycle");
    property p_shift_on_fall;
        io_oe != 4'h0 && $past(io_oe) != 4'h0 && $changed(io_out) |-> !$past(sclk, 2);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("output moved off falling edge");
    property p_addr_step;
        read_active && $past(read_active) && $changed(mem_addr) |-> mem_addr == $past(mem_addr) + 24'h1
            || (!wrap_disable_bit && mem_addr == (($past(mem_addr) & ~sec_mask) | (($past(mem_addr) + 24'h1) & sec_mask)));
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step wrong");
    property p_wrap_frozen;
        !$stable({wrap_disable_bit, wrap_length_bits}) |-> !read_active;
    endproperty
    a_wrap_frozen: assert property (p_wrap_frozen) else $error("wrap changed mid read");
    c_quad: cover property (read_active && io_oe == 4'hf);
    c_reject: cover property (cmd_rejected);
    c_wrap: cover property (!wrap_disable_bit && read_active);
endmodule // flash_read_core_assertions
bind flash_read_core flash_read_core_assertions chk (.clk_sys(clk_sys), .srst(srst), .cs_n(cs_n), .sclk(sclk),
    .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit), .write_busy(write_busy),
    .mem_addr(mem_addr), .cmd_rejected(cmd_rejected), .wrap_disable_bit(wrap_disable_bit),
    .wrap_length_bits(wrap_length_bits), .read_active(read_active));
`default_nettype wire

// File: dv/spi_host_model.sv
// Host controller model driving the flash link
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    output var  logic       cs_n,
    output var  logic       sclk,
    output var  logic [3:0] h_dat,
    output var  logic [3:0] h_oe,
    input  wire logic [3:0] io
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        h_dat = 4'h0;
        h_oe = 4'h0;
    end
    task automatic start;
        #7 cs_n = 1'b0;
        #160;
    endtask
    // Last clock may release before its fall
    task automatic shift(input logic [31:0] v, input int nbits, input int lanes, input bit rel);
        for (int i = nbits; i > 0; i -= lanes) begin
            h_oe = (lanes == 4) ? 4'hf : (lanes == 2) ? 4'h3 : 4'h1;
            h_dat = 4'((v >> (i - lanes)) & ((32'h1 << lanes) - 1));
            #160 sclk = 1'b1;
            #150;
            if (rel && i == lanes) h_oe = 4'h0;
            #10 sclk = 1'b0;
        end
    endtask
    // Released lanes float
    task automatic dummy(input int n);
        repeat (n) begin
            h_oe = 4'h0;
            h_dat = ~h_dat;
            #160 sclk = 1'b1;
            #160 sclk = 1'b0;
        end
    endtask
    task automatic get(input int lanes, output logic [7:0] b);
        b = 8'h0;
        repeat (8 / lanes) begin
            h_dat = ~h_dat;
            #160 sclk = 1'b1;
            #150;
            b = (lanes == 1) ? {b[6:0], io[1]} : (lanes == 2) ? {b[5:0], io[1:0]} : {b[3:0], io};
            #10 sclk = 1'b0;
        end
    endtask
    task automatic stop;
        #160 cs_n = 1'b1;
        h_oe = 4'h0;
        #480;
    endtask
endmodule // spi_host_model
`default_nettype wire

// File: dv/testbench.sv
// Bench for the flash read core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import flash_read_pkg::*;
    typedef struct {logic [7:0] op; int al; int dm; int dl; logic [23:0] addr; int n; logic [7:0] wb;} row_t;
    logic              clk_sys, srst, quad_enable_bit, write_busy, cs_n, sclk;
    logic              cmd_rejected, wrap_disable_bit, read_active, wrap_on;
    logic [3:0]        io_out, io_oe, h_dat, h_oe, io;
    logic [1:0]        wrap_length_bits;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]        mem_data;
    int                n_mismatch = 0;
    int                n_checks = 0;
    row_t rows [11] = '{
        '{OP_FAST_READ, 1, 8, 1, 24'hfffffe, 3, 8'hff}, '{OP_DUAL_OUT, 1, 8, 2, 24'h000107, 3, 8'h00},
        '{OP_DUAL_IO, 2, 4, 2, 24'hfffffe, 3, 8'hff}, '{OP_QUAD_OUT, 1, 8, 4, 24'h0000fe, 3, 8'h60},
        '{OP_QUAD_IO, 4, 6, 4, 24'hfffffe, 3, 8'hff}, '{OP_QUAD_IO, 4, 6, 4, 24'h00023e, 4, 8'h60},
        '{OP_QUAD_IO, 4, 6, 4, 24'h000107, 3, 8'h10}, '{OP_QUAD_WORD, 4, 2, 4, 24'h000106, 6, 8'h00},
        '{OP_QUAD_WORD, 4, 2, 4, 24'h0002fe, 3, 8'hff}, '{OP_QUAD_OCTAL, 4, 0, 4, 24'h000310, 18, 8'h20},
        '{OP_QUAD_OCTAL, 4, 0, 4, 24'h000410, 34, 8'h40}};
    // Lane: device, host, else floating
    assign io = (io_oe & io_out) | (~io_oe & h_oe & h_dat) | (~io_oe & ~h_oe & ~h_dat);
    assign mem_data = pat(mem_addr);
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16];
    endfunction
    flash_read_core uut (.clk_sys(clk_sys), .srst(srst), .cs_n(cs_n), .sclk(sclk), .io_in(io), .io_out(io_out),
        .io_oe(io_oe), .quad_enable_bit(quad_enable_bit), .write_busy(write_busy), .mem_addr(mem_addr),
        .mem_data(mem_data), .cmd_rejected(cmd_rejected), .wrap_disable_bit(wrap_disable_bit),
        .wrap_length_bits(wrap_length_bits), .read_active(read_active));
    spi_host_model host (.cs_n(cs_n), .sclk(sclk), .h_dat(h_dat), .h_oe(h_oe), .io(io));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic do_reset(input int n);
        @(negedge clk_sys) srst = 1'b1;
        repeat (n) @(negedge clk_sys);
        srst = 1'b0;
        wrap_on = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic set_wrap(input logic [7:0] wb);
        host.start;
        host.shift({24'h0, OP_SET_WRAP}, 8, 1, 1'b0);
        host.shift(32'h0, 24, 1, 1'b0);
        host.shift({24'h0, wb}, 8, 1, 1'b0);
        host.stop;
        wrap_on = !wb[4];
        check("wrap_disable_bit", {31'h0, wb[4]}, {31'h0, wrap_disable_bit});
        check("wrap_length_bits", {30'h0, wb[6:5]}, {30'h0, wrap_length_bits});
    endtask
    task automatic run(input row_t r, input bit no_op);
        logic [23:0] a;
        logic [23:0] m;
        logic [7:0]  b;
        m = (24'h8 << wrap_length_bits) - 24'h1;
        a = r.addr;
        host.start;
        if (!no_op) host.shift({24'h0, r.op}, 8, 1, 1'b0);
        host.shift({8'h0, r.addr}, 24, r.al, r.dm == 0);
        host.dummy(r.dm);
        repeat (r.n) begin
            host.get(r.dl, b);
            check("read data", {24'h0, pat(a)}, {24'h0, b});
            check("io_oe", (r.dl == 4) ? 32'hf : (r.dl == 2) ? 32'h3 : 32'h2, {28'h0, io_oe});
            a = (wrap_on && r.al == 4) ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
        end
        host.stop;
        check("io_oe after frame", 32'h0, {28'h0, io_oe});
    endtask
    initial begin
        #2_000_000;
        n_mismatch++;
        results();
    end
    initial begin
        logic [7:0] b;
        srst = 1'b1;
        quad_enable_bit = 1'b1;
        write_busy = 1'b0;
        do_reset(20);
        for (int k = 0; k < 11; k++) begin
            do_reset(2);
            if (rows[k].wb != 8'hff) set_wrap(rows[k].wb);
            run(rows[k], 1'b0);
        end
        do_reset(2);
        check("reset state", 32'h10, {27'h0, wrap_disable_bit, wrap_length_bits, io_oe[0], read_active});
        set_wrap(8'h20);
        run(rows[5], 1'b0);
        run('{OP_QUAD_IO, 4, 6, 4, 24'h00052e, 4, 8'hff}, 1'b1);
        for (int k = 0; k < 3; k++) begin
            do_reset(2);
            quad_enable_bit = (k == 2);
            write_busy = (k == 2);
            host.start;
            host.shift({24'h0, (k == 0) ? OP_QUAD_OUT : (k == 1) ? OP_QUAD_IO : OP_FAST_READ}, 8, 1, 1'b0);
            host.shift(32'h123, 24, 1, 1'b0);
            host.dummy(8);
            host.get(4, b);
            check("cmd_rejected", 32'h1, {31'h0, cmd_rejected});
            check("io_oe when rejected", 32'h0, {28'h0, io_oe});
            host.stop;
        end
        results();
    end
endmodule // testbench
`default_nettype wire
